//--- hw/ccr_core_regs.sv
/*
 * CPU core special registers: stack pointer, status word, accumulator,
 * operand and extension registers, dual data pointers, mode control, RAM page,
 * plus internal/external data memory address decode.
 * Assumes the execution unit issues at most one op per clock and owns the RAMs.
 */
`timescale 1ns/10ps
`default_nettype none

module ccr_core_regs (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire ccr_pkg::ccr_op_t op,
    input  wire logic             op_we,
    input  wire logic [7:0]       op_addr,
    input  wire logic [7:0]       op_wdata,
    input  wire logic             flag_we,
    input  wire logic             alu_carry,
    input  wire logic             alu_aux_carry,
    input  wire logic             alu_overflow,
    input  wire logic             acc_we,
    input  wire logic [7:0]       acc_wdata,
    output logic [7:0]            main_working_reg,
    output logic [7:0]            program_status_word,
    output logic [7:0]            iram_addr,
    output logic                  iram_re,
    output logic                  iram_we,
    output logic [7:0]            iram_wdata,
    output logic                  sfr_rd_valid,
    output logic [7:0]            sfr_rdata,
    output logic                  ext_sfr_re,
    output logic                  ext_sfr_we,
    output logic [7:0]            ext_sfr_addr,
    output logic                  ext_sfr_bank,
    output logic [7:0]            ext_sfr_wdata,
    output logic [15:0]           xram_addr,
    output logic                  xram_re,
    output logic                  xram_we,
    output logic [7:0]            xram_wdata
);
    import ccr_pkg::*;

    logic [7:0]  stack_ptr;
    logic [7:0]  acc;
    logic [7:0]  operand_reg;
    logic [7:0]  extension_accumulator;
    logic        carry_flag;
    logic        aux_carry_flag;
    logic        user_flag_a;
    logic [1:0]  reg_bank_sel;
    logic        overflow_flag;
    logic        user_flag_b;
    logic        parity_flag;
    logic [7:0]  cpu_mode_ctl;
    logic [5:0]  ext_ram_page_sel;
    logic [7:0]  ptr_lo [2];
    logic [7:0]  ptr_hi [2];

    // op decode
    wire is_push  = (op == CCR_OP_PUSH);
    wire is_pop   = (op == CCR_OP_POP);
    wire is_mul   = (op == CCR_OP_MUL);
    wire is_div   = (op == CCR_OP_DIV);
    wire is_dir   = (op == CCR_OP_DIR);
    wire is_ind   = (op == CCR_OP_IND);
    wire is_reg   = (op == CCR_OP_REG);
    wire is_xri   = (op == CCR_OP_XRI);
    wire is_xptr  = (op == CCR_OP_XPTR);
    wire is_pinc  = (op == CCR_OP_PINC);
    wire is_pload = (op == CCR_OP_PLOAD);

    wire pointer_select  = cpu_mode_ctl[MODE_DPS];
    wire wide_product_en = cpu_mode_ctl[MODE_MUL];
    wire wide_quotient_en = cpu_mode_ctl[MODE_DIV];
    wire sfr_bank_select = cpu_mode_ctl[MODE_BKS];

    // addressing mode alone separates upper RAM from special registers
    wire sfr_access = is_dir & op_addr[7];
    wire ram_access = (is_dir & ~op_addr[7]) | is_ind;
    wire sfr_wr     = sfr_access & op_we;

    wire hit_sp   = (op_addr == SFR_SP);
    wire hit_dpl  = (op_addr == SFR_DPL);
    wire hit_dph  = (op_addr == SFR_DPH);
    wire hit_alt_pointer_low = (op_addr == SFR_ALT_POINTER_LOW);
    wire hit_alt_pointer_high = (op_addr == SFR_ALT_POINTER_HIGH);
    wire hit_mode = (op_addr == SFR_MODE);
    wire hit_psw  = (op_addr == SFR_PSW);
    wire hit_acc  = (op_addr == SFR_ACC);
    wire hit_b    = (op_addr == SFR_B);
    wire hit_aux  = (op_addr == SFR_AUX);
    wire hit_page = (op_addr == SFR_PAGE);
    wire hit_local = hit_sp | hit_dpl | hit_dph | hit_alt_pointer_low | hit_alt_pointer_high | hit_mode
                   | hit_psw | hit_acc | hit_b | hit_aux | hit_page;

    wire [7:0] psw_view = {carry_flag, aux_carry_flag, user_flag_a, reg_bank_sel,
                           overflow_flag, user_flag_b, parity_flag};

    wire [7:0] local_rdata =
        hit_sp   ? stack_ptr :
        hit_dpl  ? ptr_lo[0] :
        hit_dph  ? ptr_hi[0] :
        hit_alt_pointer_low ? ptr_lo[1] :
        hit_alt_pointer_high ? ptr_hi[1] :
        hit_mode ? (cpu_mode_ctl & MODE_MASK) :
        hit_psw  ? psw_view :
        hit_acc  ? acc :
        hit_b    ? operand_reg :
        hit_aux  ? extension_accumulator :
        hit_page ? {2'b00, ext_ram_page_sel} : BYTE_RST;

    // multiply: narrow uses a zero extension byte
    wire [15:0] mul_a   = wide_product_en ? {extension_accumulator, acc} : {8'h00, acc};
    wire [23:0] product = {8'h00, mul_a} * {16'h0000, operand_reg};
    wire        mul_ov  = wide_product_en ? (|product[23:16]) : (|product[15:8]);

    // divide: zero divisor leaves the registers, raises overflow and clears carry
    wire [15:0] div_a    = wide_quotient_en ? {extension_accumulator, acc} : {8'h00, acc};
    wire        div_zero = (operand_reg == 8'h00);
    wire [15:0] quotient = div_zero ? div_a : (div_a / {8'h00, operand_reg});
    wire [15:0] rem_wide = div_zero ? {8'h00, operand_reg} : (div_a % {8'h00, operand_reg});

    wire [7:0] next_acc =
        is_mul ? product[7:0] :
        is_div ? quotient[7:0] :
        (sfr_wr & hit_acc) ? op_wdata :
        acc_we ? acc_wdata : acc;

    wire [7:0] next_operand =
        is_mul ? product[15:8] :
        is_div ? rem_wide[7:0] :
        (sfr_wr & hit_b) ? op_wdata : operand_reg;

    wire [7:0] next_ext =
        (is_mul & wide_product_en) ? product[23:16] :
        (is_div & wide_quotient_en) ? quotient[15:8] :
        (sfr_wr & hit_aux) ? op_wdata : extension_accumulator;

    // stack: pre-increment on push, post-decrement on pop
    wire [7:0] sp_inc = stack_ptr + 8'h01;
    wire [7:0] sp_dec = stack_ptr - 8'h01;
    wire [7:0] next_sp =
        is_push ? sp_inc :
        is_pop  ? sp_dec :
        (sfr_wr & hit_sp) ? op_wdata : stack_ptr;

    // working register address from bank select
    wire [7:0] reg_addr = {3'b000, reg_bank_sel, op_addr[2:0]};

    wire [7:0] next_iram_addr =
        is_push ? sp_inc :
        is_pop  ? stack_ptr :
        is_reg  ? reg_addr : op_addr;
    wire next_iram_we = is_push | ((ram_access | is_reg) & op_we);
    wire next_iram_re = is_pop | ((ram_access | is_reg) & ~op_we);

    wire [15:0] sel_ptr = {ptr_hi[pointer_select], ptr_lo[pointer_select]};
    wire [15:0] ptr_inc = sel_ptr + 16'h0001;
    wire [15:0] next_xram_addr =
        is_xri ? {2'b00, ext_ram_page_sel, op_addr} : sel_ptr;

    // flags: hardware update wins over a software write in the same cycle
    wire next_cy = (is_mul | is_div) ? 1'b0 :
                   flag_we ? alu_carry :
                   (sfr_wr & hit_psw) ? op_wdata[PSW_CY] : carry_flag;
    wire next_ac = flag_we ? alu_aux_carry :
                   (sfr_wr & hit_psw) ? op_wdata[PSW_AC] : aux_carry_flag;
    wire next_ov = is_mul ? mul_ov :
                   is_div ? div_zero :
                   flag_we ? alu_overflow :
                   (sfr_wr & hit_psw) ? op_wdata[PSW_OV] : overflow_flag;

    wire psw_wr  = sfr_wr & hit_psw;
    wire mode_wr = sfr_wr & hit_mode;
    wire page_wr = sfr_wr & hit_page;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stack_ptr             <= SP_RST;
            acc                   <= BYTE_RST;
            operand_reg           <= BYTE_RST;
            extension_accumulator <= BYTE_RST;
            parity_flag           <= 1'b0;
        end else begin
            stack_ptr             <= next_sp;
            acc                   <= next_acc;
            operand_reg           <= next_operand;
            extension_accumulator <= next_ext;
            parity_flag           <= ^next_acc;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            carry_flag     <= 1'b0;
            aux_carry_flag <= 1'b0;
            overflow_flag  <= 1'b0;
            user_flag_a    <= 1'b0;
            user_flag_b    <= 1'b0;
            reg_bank_sel   <= 2'b00;
        end else begin
            carry_flag     <= next_cy;
            aux_carry_flag <= next_ac;
            overflow_flag  <= next_ov;
            if (psw_wr) begin
                user_flag_a  <= op_wdata[PSW_F0];
                user_flag_b  <= op_wdata[PSW_F1];
                reg_bank_sel <= op_wdata[PSW_RS1:PSW_RS0];
            end
        end
    end

    // only implemented bits are stored, the rest stay zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_mode_ctl     <= BYTE_RST;
            ext_ram_page_sel <= PAGE_RST;
        end else begin
            if (mode_wr) begin
                cpu_mode_ctl <= op_wdata & MODE_MASK;
            end
            if (page_wr) begin
                ext_ram_page_sel <= op_wdata[5:0];
            end
        end
    end

    // two identical pointers; byte writes and whole-word ops share one path
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            wire sel_me = (pointer_select == 1'(gi));
            wire wr_lo  = sfr_wr & ((gi == 0) ? hit_dpl : hit_alt_pointer_low);
            wire wr_hi  = sfr_wr & ((gi == 0) ? hit_dph : hit_alt_pointer_high);
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    ptr_lo[gi] <= BYTE_RST;
                    ptr_hi[gi] <= BYTE_RST;
                end else if (sel_me & is_pload) begin
                    ptr_lo[gi] <= op_wdata;
                    ptr_hi[gi] <= op_addr;
                end else if (sel_me & is_pinc) begin
                    ptr_lo[gi] <= ptr_inc[7:0];
                    ptr_hi[gi] <= ptr_inc[15:8];
                end else begin
                    if (wr_lo) begin
                        ptr_lo[gi] <= op_wdata;
                    end
                    if (wr_hi) begin
                        ptr_hi[gi] <= op_wdata;
                    end
                end
            end
        end
    endgenerate

    // memory and register port outputs, all registered
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            iram_addr     <= BYTE_RST;
            iram_re       <= 1'b0;
            iram_we       <= 1'b0;
            iram_wdata    <= BYTE_RST;
            sfr_rd_valid  <= 1'b0;
            sfr_rdata     <= BYTE_RST;
            ext_sfr_re    <= 1'b0;
            ext_sfr_we    <= 1'b0;
            ext_sfr_addr  <= BYTE_RST;
            ext_sfr_bank  <= 1'b0;
            ext_sfr_wdata <= BYTE_RST;
            xram_addr     <= 16'h0000;
            xram_re       <= 1'b0;
            xram_we       <= 1'b0;
            xram_wdata    <= BYTE_RST;
        end else begin
            iram_addr     <= next_iram_addr;
            iram_re       <= next_iram_re;
            iram_we       <= next_iram_we;
            iram_wdata    <= op_wdata;
            sfr_rd_valid  <= sfr_access & ~op_we & hit_local;
            sfr_rdata     <= (sfr_access & hit_local) ? local_rdata : BYTE_RST;
            ext_sfr_re    <= sfr_access & ~op_we & ~hit_local;
            ext_sfr_we    <= sfr_wr & ~hit_local;
            ext_sfr_addr  <= op_addr;
            ext_sfr_bank  <= sfr_bank_select;
            ext_sfr_wdata <= op_wdata;
            xram_addr     <= next_xram_addr;
            xram_re       <= (is_xri | is_xptr) & ~op_we;
            xram_we       <= (is_xri | is_xptr) & op_we;
            xram_wdata    <= op_wdata;
        end
    end

    assign main_working_reg    = acc;
    assign program_status_word = psw_view;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_push;
        op == CCR_OP_PUSH;
    endsequence

    sequence s_pop;
        op == CCR_OP_POP;
    endsequence

    sequence s_narrow_mul;
        (op == CCR_OP_MUL) && !wide_product_en;
    endsequence

    a_push_preinc: assert property (s_push |=> (stack_ptr == $past(stack_ptr) + 8'h01)
        && iram_we && (iram_addr == stack_ptr))
        else $error("push did not pre-increment stack");

    a_pop_postdec: assert property (s_pop |=> iram_re && (iram_addr == $past(stack_ptr))
        && (stack_ptr == $past(stack_ptr) - 8'h01))
        else $error("pop did not read before decrement");

    a_reset_values: assert property ($rose(nrst) |-> (stack_ptr == SP_RST)
        && (cpu_mode_ctl == BYTE_RST))
        else $error("reset values wrong");

    a_parity_track: assert property (parity_flag == ^acc)
        else $error("parity flag mismatch");

    a_bank_map: assert property ((op == CCR_OP_REG) |=>
        iram_addr == {3'b000, $past(reg_bank_sel), $past(op_addr[2:0])})
        else $error("working register bank mapping wrong");

    a_ptr_select: assert property ((op == CCR_OP_XPTR) |=>
        xram_addr == $past(sel_ptr))
        else $error("external access used wrong pointer");

    a_mul_narrow: assert property (s_narrow_mul |=>
        {operand_reg, acc} == $past(acc) * $past(operand_reg))
        else $error("narrow multiply result wrong");

    a_upper_ram: assert property ((op == CCR_OP_IND) && op_addr[7] |=>
        (iram_re || iram_we) && !sfr_rd_valid && !ext_sfr_re && !ext_sfr_we)
        else $error("indirect upper access reached special registers");

    a_direct_sfr: assert property ((op == CCR_OP_DIR) && op_addr[7] |=>
        !iram_re && !iram_we)
        else $error("direct upper access reached RAM");

    a_mode_unimpl: assert property ((cpu_mode_ctl & ~MODE_MASK) == 8'h00
        && !(sfr_rd_valid && (ext_sfr_addr == SFR_PAGE) && (|sfr_rdata[7:6])))
        else $error("unimplemented mode bits set");

endmodule

`default_nettype wire

//--- hw/ccr_pkg.sv
/*
 * Constants, opcodes and register layout of the CPU core register block.
 * Assumes one CPU clock and one active-low reset shared with the execution unit.
 */
package ccr_pkg;

    // special register offsets, identical in both banks
    localparam logic [7:0] SFR_SP    = 8'h81;
    localparam logic [7:0] SFR_DPL   = 8'h82;
    localparam logic [7:0] SFR_DPH   = 8'h83;
    localparam logic [7:0] SFR_ALT_POINTER_LOW  = 8'h84;
    localparam logic [7:0] SFR_ALT_POINTER_HIGH  = 8'h85;
    localparam logic [7:0] SFR_MODE  = 8'h86;
    localparam logic [7:0] SFR_PSW   = 8'hD0;
    localparam logic [7:0] SFR_ACC   = 8'hE0;
    localparam logic [7:0] SFR_B     = 8'hF0;
    localparam logic [7:0] SFR_AUX   = 8'hF1;
    localparam logic [7:0] SFR_PAGE  = 8'hF7;

    // reset values
    localparam logic [7:0] SP_RST    = 8'h07;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    localparam logic [5:0] PAGE_RST  = 6'h00;

    // status word bit positions
    localparam int PSW_CY  = 7;
    localparam int PSW_AC  = 6;
    localparam int PSW_F0  = 5;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV  = 2;
    localparam int PSW_F1  = 1;

    // mode control bit positions and implemented-bit mask
    localparam int MODE_BKS = 6;
    localparam int MODE_DIV = 3;
    localparam int MODE_MUL = 2;
    localparam int MODE_DPS = 0;
    localparam logic [7:0] MODE_MASK = 8'h4D;
    localparam logic [7:0] PAGE_MASK = 8'h3F;

    typedef enum logic [3:0] {
        CCR_OP_NONE  = 4'h0,
        CCR_OP_PUSH  = 4'h1,
        CCR_OP_POP   = 4'h2,
        CCR_OP_MUL   = 4'h3,
        CCR_OP_DIV   = 4'h4,
        CCR_OP_DIR   = 4'h5,
        CCR_OP_IND   = 4'h6,
        CCR_OP_REG   = 4'h7,
        CCR_OP_XRI   = 4'h8,
        CCR_OP_XPTR  = 4'h9,
        CCR_OP_PINC  = 4'hA,
        CCR_OP_PLOAD = 4'hB
    } ccr_op_t;

endpackage

//--- verif/ccr_mem_model.sv
/*
 * Partner model: internal and external data memories behind the core regs.
 * Assumes one-cycle read/write strobes from the core on ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module ccr_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [7:0]  iram_addr,
    input  wire logic        iram_re,
    input  wire logic        iram_we,
    input  wire logic [7:0]  iram_wdata,
    input  wire logic [15:0] xram_addr,
    input  wire logic        xram_we,
    input  wire logic [7:0]  xram_wdata,
    output logic [7:0]       iram_rdata
);
    logic [7:0] iram [256]; // whole 00-FF, upper half apart from special regs
    logic [7:0] xram [256]; // only 256 bytes: page bits must stay 0

    // read data not held: idle cycles show the inverse, so stale reads show up
    always_ff @(posedge ref_clk) begin
        if (iram_we) iram[iram_addr] <= iram_wdata;
        if (xram_we) xram[xram_addr[7:0]] <= xram_wdata;
        iram_rdata <= iram_re ? iram[iram_addr] : ~iram_rdata;
    end
endmodule

`default_nettype wire

//--- verif/ccr_core_regs_tb.sv
/*
 * Self-checking bench for ccr_core_regs with the memory partner model.
 * Assumes a 25 MHz ref_clk and one op per clock with no handshake.
 */
`timescale 1ns/10ps
`default_nettype none

module ccr_core_regs_tb;
    import ccr_pkg::*;
    logic        ref_clk, nrst, op_we, flag_we, acc_we;
    logic        alu_carry, alu_aux_carry, alu_overflow;
    ccr_op_t     op;
    logic [7:0]  op_addr, op_wdata, acc_wdata, main_working_reg, program_status_word;
    logic [7:0]  iram_addr, iram_wdata, iram_rdata, sfr_rdata, ext_sfr_addr, ext_sfr_wdata;
    logic [7:0]  xram_wdata;
    logic        iram_re, iram_we, sfr_rd_valid, ext_sfr_re, ext_sfr_we, ext_sfr_bank;
    logic        xram_re, xram_we;
    logic [15:0] xram_addr;
    int          err_count, checks_done;

    ccr_core_regs u_ccr_core_regs (.ref_clk, .nrst, .op, .op_we, .op_addr, .op_wdata,
        .flag_we, .alu_carry, .alu_aux_carry, .alu_overflow, .acc_we, .acc_wdata,
        .main_working_reg, .program_status_word, .iram_addr, .iram_re, .iram_we,
        .iram_wdata, .sfr_rd_valid, .sfr_rdata, .ext_sfr_re, .ext_sfr_we, .ext_sfr_addr,
        .ext_sfr_bank, .ext_sfr_wdata, .xram_addr, .xram_re, .xram_we, .xram_wdata);
    ccr_mem_model u_ccr_mem_model (.ref_clk, .iram_addr, .iram_re, .iram_we, .iram_wdata,
        .xram_addr, .xram_we, .xram_wdata, .iram_rdata);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // answer lands on the taking edge, one cycle after the drive, sampled 1 ns later
    task automatic do_op(input ccr_op_t o, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        op <= o;
        op_we <= w;
        op_addr <= a;
        op_wdata <= d;
        @(posedge ref_clk);
        op <= CCR_OP_NONE;
        op_we <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        do_op(CCR_OP_DIR, 1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        do_op(CCR_OP_DIR, 1'b0, a, 8'h00);
        chk({sfr_rd_valid, sfr_rdata}, {1'b1, exp});
    endtask

    task automatic alu(input logic aw, input logic [7:0] v, input logic fw, input logic [2:0] f);
        @(posedge ref_clk);
        acc_we <= aw;
        acc_wdata <= v;
        flag_we <= fw;
        {alu_carry, alu_aux_carry, alu_overflow} <= f;
        @(posedge ref_clk);
        acc_we <= 1'b0;
        flag_we <= 1'b0;
        #1;
    endtask

    task automatic t_stack;
        rd(SFR_SP, 8'h07);
        do_op(CCR_OP_PUSH, 1'b0, 8'h00, 8'hA5);
        chk({iram_we, iram_addr, iram_wdata}, {1'b1, 8'h08, 8'hA5});
        do_op(CCR_OP_POP, 1'b0, 8'h00, 8'h00);
        chk({iram_re, iram_addr}, {1'b1, 8'h08});
        @(posedge ref_clk);
        #1;
        chk(iram_rdata, 8'hA5);
        rd(SFR_SP, 8'h07);
        wr(SFR_SP, 8'hFE);
        do_op(CCR_OP_PUSH, 1'b0, 8'h00, 8'h3C);
        chk({iram_we, iram_addr}, {1'b1, 8'hFF});
        do_op(CCR_OP_POP, 1'b0, 8'h00, 8'h00);
        chk({iram_re, iram_addr}, {1'b1, 8'hFF});
        $display("test stack done");
    endtask

    task automatic t_psw;
        alu(1'b1, 8'h07, 1'b0, 3'b000);
        chk(program_status_word, 8'h01);
        alu(1'b1, 8'h03, 1'b0, 3'b000);
        chk(program_status_word, 8'h00);
        wr(SFR_PSW, 8'hFF);
        chk(program_status_word, 8'hFE);
        alu(1'b0, 8'h00, 1'b1, 3'b010);
        chk(program_status_word, 8'h7A);
        alu(1'b0, 8'h00, 1'b1, 3'b101);
        chk(program_status_word, 8'hBE);
        for (int i = 0; i < 4; i++) begin
            wr(SFR_PSW, 8'(i * 8));
            do_op(CCR_OP_REG, 1'b0, 8'h05, 8'h00);
            chk({iram_re, iram_addr}, {1'b1, 8'(i * 8 + 5)});
        end
        chk(program_status_word, 8'h18);
        $display("test status word done");
    endtask

    task automatic t_muldiv;
        rd(SFR_MODE, 8'h00);
        wr(SFR_ACC, 8'h5A);
        wr(SFR_B, 8'h03);
        do_op(CCR_OP_MUL, 1'b0, 8'h00, 8'h00);
        chk({main_working_reg, program_status_word[PSW_OV], program_status_word[PSW_CY]},
            {8'h0E, 2'b10});
        rd(SFR_B, 8'h01);
        wr(SFR_MODE, 8'h04);
        wr(SFR_ACC, 8'h34);
        wr(SFR_B, 8'h10);
        wr(SFR_AUX, 8'h12);
        do_op(CCR_OP_MUL, 1'b0, 8'h00, 8'h00);
        chk(main_working_reg, 8'h40);
        rd(SFR_B, 8'h23);
        rd(SFR_AUX, 8'h01);
        wr(SFR_MODE, 8'h00);
        wr(SFR_ACC, 8'hC8);
        wr(SFR_B, 8'h07);
        do_op(CCR_OP_DIV, 1'b0, 8'h00, 8'h00);
        chk(main_working_reg, 8'h1C);
        rd(SFR_B, 8'h04);
        wr(SFR_MODE, 8'h08);
        wr(SFR_ACC, 8'h23);
        wr(SFR_AUX, 8'h01);
        wr(SFR_B, 8'h10);
        do_op(CCR_OP_DIV, 1'b0, 8'h00, 8'h00);
        chk(main_working_reg, 8'h12);
        rd(SFR_B, 8'h03);
        rd(SFR_AUX, 8'h00);
        $display("test multiply divide done");
    endtask

    // mid-run reset: wide divide mode was left on above
    task automatic t_reset;
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(SFR_MODE, 8'h00);
        rd(SFR_SP, 8'h07);
        $display("test reset done");
    endtask

    task automatic t_map;
        do_op(CCR_OP_PLOAD, 1'b0, 8'h12, 8'h34);
        do_op(CCR_OP_XPTR, 1'b0, 8'h00, 8'h00);
        chk({xram_re, xram_addr}, {1'b1, 16'h1234});
        wr(SFR_MODE, 8'h01);
        do_op(CCR_OP_PLOAD, 1'b0, 8'h56, 8'h78);
        wr(SFR_ALT_POINTER_LOW, 8'hCD);
        do_op(CCR_OP_XPTR, 1'b1, 8'h00, 8'hAB);
        chk({xram_we, xram_addr, xram_wdata}, {1'b1, 16'h56CD, 8'hAB});
        rd(SFR_DPL, 8'h34);
        rd(SFR_ALT_POINTER_HIGH, 8'h56);
        wr(SFR_MODE, 8'hFF);
        rd(SFR_MODE, 8'h4D);
        do_op(CCR_OP_DIR, 1'b0, 8'h90, 8'h00);
        chk({ext_sfr_re, ext_sfr_bank, ext_sfr_addr, iram_re}, {2'b11, 8'h90, 1'b0});
        wr(SFR_MODE, 8'h00);
        do_op(CCR_OP_DIR, 1'b1, 8'h90, 8'h55);
        chk({ext_sfr_we, ext_sfr_bank, ext_sfr_wdata, iram_we}, {2'b10, 8'h55, 1'b0});
        do_op(CCR_OP_IND, 1'b0, 8'h90, 8'h00);
        chk({iram_re, iram_addr, ext_sfr_re}, {1'b1, 8'h90, 1'b0});
        do_op(CCR_OP_DIR, 1'b0, 8'h30, 8'h00);
        chk({iram_re, iram_addr, ext_sfr_re}, {1'b1, 8'h30, 1'b0});
        do_op(CCR_OP_IND, 1'b1, 8'h30, 8'h66);
        chk({iram_we, iram_addr, iram_wdata}, {1'b1, 8'h30, 8'h66});
        wr(SFR_PAGE, 8'hFF);
        rd(SFR_PAGE, 8'h3F);
        wr(SFR_PAGE, 8'h00); // page kept 0 for any real traffic
        do_op(CCR_OP_XRI, 1'b1, 8'h44, 8'h77);
        chk({xram_we, xram_addr, xram_wdata}, {1'b1, 16'h0044, 8'h77});
        do_op(CCR_OP_XRI, 1'b0, 8'h44, 8'h00);
        chk({xram_re, xram_addr}, {1'b1, 16'h0044});
        do_op(CCR_OP_PINC, 1'b0, 8'h00, 8'h00);
        do_op(CCR_OP_XPTR, 1'b0, 8'h00, 8'h00);
        chk({xram_re, xram_addr}, {1'b1, 16'h1235});
        $display("test address map done");
    endtask

    initial begin
        err_count = 0;
        checks_done = 0;
        nrst = 1'b0;
        op = CCR_OP_NONE;
        {op_we, flag_we, acc_we, alu_carry, alu_aux_carry, alu_overflow} = 6'h00;
        {op_addr, op_wdata, acc_wdata} = 24'h000000;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        t_stack;
        t_psw;
        t_muldiv;
        t_reset;
        t_map;
        final_report;
    end

    // hang guard: far beyond the roughly 150 cycles the run needs
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        $display("CHECK FAILED t=%0t timeout", $time);
        final_report;
    end
endmodule

`default_nettype wire
